// ### pkg/nrf_pkg.sv
// register file access constants and carriers for the 4-bit core
// assumes the core decodes transfer instructions into one request per cycle
package nrf_pkg;
    localparam int NIB_W      = 4;
    localparam int RF_ADDR_W  = 7;
    localparam int ROW_W      = 3;
    localparam int COL_W      = 4;
    localparam int RF_DEPTH   = 128;
    localparam int CTRL_DEPTH = 64;
    localparam logic [6:0] WINDOW_ADDR   = 7'h78;
    localparam logic [6:0] OVERLAP_BASE  = 7'h40;
    localparam logic [6:0] HOLE_LO       = 7'h40;
    localparam logic [6:0] HOLE_HI       = 7'h6e;
    localparam logic [5:0] TIMER_CTRL    = 6'h11;
    localparam int TIMER_RESTART_BIT     = 2;
    localparam logic [3:0] NIB_RESET     = 4'h0;
    localparam logic [3:0] UNUSED_READ   = 4'h0;
    localparam logic [2:0] ROW_RESET     = 3'h0;

    typedef enum logic [1:0] {
        NRF_OP_NONE  = 2'b00,
        NRF_OP_READ  = 2'b01,
        NRF_OP_WRITE = 2'b10,
        NRF_OP_ALU   = 2'b11
    } nrf_op_t;

    typedef enum logic [1:0] {
        NRF_ALU_MOV = 2'b00,
        NRF_ALU_ADD = 2'b01,
        NRF_ALU_AND = 2'b10,
        NRF_ALU_OR  = 2'b11
    } nrf_alu_t;

    // one instruction request from the core
    typedef struct packed {
        nrf_op_t    op;
        nrf_alu_t   alu;
        logic [3:0] col;     // general row column
        logic [6:0] addr;    // file address or memory address
    } nrf_req_t;
endpackage : nrf_pkg

// ### rtl/nrf_core.sv
// register file, window nibble and general row operand datapath
// assumes requests come from same-clock core logic, one per cycle
//
// Operation
// RQ1: general row is sixteen memory nibbles
// RQ2: three-bit row pointer selects rows 0-7
// RQ3: software avoids uninstalled rows 40h-6eh
// RQ4: one-instruction operation general row with memory
// RQ5: file holds 128 four-bit locations
// RQ6: address is row and column index
// RQ7: addresses 00h-3fh are control area
// RQ8: 40h-7fh share cells with memory
// RQ9: file read loads window nibble
// RQ10: file write stores window nibble
// RQ11: window nibble sits at 78h
// RQ12: control nibbles reachable only through transfers
// RQ13: overlap transfers use current bank memory
// RQ14: transfers never reach other memory
// RQ15: variants implement 17 or 20 control nibbles
// RQ16: control nibbles are read/write or read-only
// RQ17: timer restart flag always reads zero
// RQ18: fixed-zero bits read zero, stay zero
// RQ19: unused control reads undefined, writes ignored
// RQ20: writes to read-only controls ignored
// RQ21: transfer finishes inside its instruction cycle
//
// ------------------------------------------------------------
// design notes
// ------------------------------------------------------------
// memory is modelled as the current bank only; bank switching lives in the core
// the window nibble is ordinary data memory, so a general row operation on row 7
//   can target it as well as the transfer instructions can
// unused control nibbles read a fixed value; software must not rely on it
// the restart flag is never stored, only turned into a one-cycle pulse
// o_hole_warn is advisory only: the access itself still goes ahead
// o_window lags the window cell by one edge, except straight after a file read
`timescale 1ns/1ns
module nrf_core #(
    parameter logic [63:0] USED_MASK = 64'h0000_0000_000f_ffff, // 20 used nibbles [RQ15]
    parameter logic [63:0] RO_MASK   = 64'h0000_0000_0008_0000,
    parameter logic [3:0]  ZERO_BITS = 4'h0  // bits fixed at zero in every control
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_ce,
    input  wire nrf_pkg::nrf_req_t   i_req,
    input  wire logic                i_ptr_we,
    input  wire logic [2:0]          i_ptr,
    input  wire logic [3:0]          i_ro_data,
    output logic [3:0]               o_window,
    output logic [3:0]               o_rdata,
    output logic [2:0]               o_ptr,
    output logic                     o_timer_restart,
    output logic                     o_hole_warn
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [3:0] ctrl_mem [nrf_pkg::CTRL_DEPTH];
    logic [3:0] data_mem [nrf_pkg::RF_DEPTH];  // current bank of data memory
    logic [2:0] operand_row_pointer;
    logic [3:0] next_window;

    // row and column form the address
    function automatic logic [6:0] nrf_addr(input logic [2:0] row, input logic [3:0] col);
        nrf_addr = {row, col}; // [RQ6]
    endfunction : nrf_addr

    function automatic logic is_ctrl(input logic [6:0] a);
        is_ctrl = (a < nrf_pkg::OVERLAP_BASE); // [RQ7]
    endfunction : is_ctrl

    wire logic [6:0] gr_addr  = nrf_addr(operand_row_pointer, i_req.col); // [RQ1]
    wire logic [5:0] cidx     = i_req.addr[5:0];
    wire logic       is_rd    = i_req.op == nrf_pkg::NRF_OP_READ;
    wire logic       is_wr    = i_req.op == nrf_pkg::NRF_OP_WRITE;
    wire logic       is_alu   = i_req.op == nrf_pkg::NRF_OP_ALU;
    wire logic       c_acc    = is_ctrl(i_req.addr);
    wire logic       ctrl_wen = is_wr && c_acc && USED_MASK[cidx] && !RO_MASK[cidx];
    wire logic [3:0] gr_val   = data_mem[gr_addr];
    wire logic [3:0] mem_val  = data_mem[i_req.addr];
    logic [3:0] alu_res;
    logic [3:0] ctrl_rd;

    // ------------------------------------------------------------
    // operand arithmetic and control read mux
    // ------------------------------------------------------------
    always_comb begin
        unique case (i_req.alu)
            nrf_pkg::NRF_ALU_MOV: alu_res = mem_val;
            nrf_pkg::NRF_ALU_ADD: alu_res = 4'(gr_val + mem_val); // [RQ4]
            nrf_pkg::NRF_ALU_AND: alu_res = gr_val & mem_val;
            nrf_pkg::NRF_ALU_OR:  alu_res = gr_val | mem_val;
        endcase
        // unused addresses give a fixed value; any value is legal there
        if (!USED_MASK[cidx]) begin
            ctrl_rd = nrf_pkg::UNUSED_READ; // [RQ19]
        end else if (RO_MASK[cidx]) begin
            ctrl_rd = i_ro_data & ~ZERO_BITS; // [RQ16]
        end else begin
            ctrl_rd = ctrl_mem[cidx];
        end
        next_window = c_acc ? ctrl_rd : mem_val; // [RQ9] [RQ13]
    end

    // ------------------------------------------------------------
    // row pointer, three effective bits
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            operand_row_pointer <= nrf_pkg::ROW_RESET;
        end else if (i_ce && i_ptr_we) begin
            operand_row_pointer <= i_ptr; // [RQ2]
        end
    end

    // ------------------------------------------------------------
    // control area writes; restart flag is a pulse, never stored
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < nrf_pkg::CTRL_DEPTH; i++) begin
                ctrl_mem[i] <= nrf_pkg::NIB_RESET;
            end
        end else if (i_ce && ctrl_wen) begin // [RQ12] [RQ19] [RQ20]
            ctrl_mem[cidx] <= data_mem[nrf_pkg::WINDOW_ADDR] & ~ZERO_BITS; // [RQ10] [RQ18]
            if (cidx == nrf_pkg::TIMER_CTRL) begin
                ctrl_mem[cidx][nrf_pkg::TIMER_RESTART_BIT] <= 1'b0; // [RQ17]
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_timer_restart <= 1'b0;
        end else if (i_ce) begin
            o_timer_restart <= ctrl_wen && cidx == nrf_pkg::TIMER_CTRL
                && data_mem[nrf_pkg::WINDOW_ADDR][nrf_pkg::TIMER_RESTART_BIT]; // [RQ17]
        end
    end

    // ------------------------------------------------------------
    // data memory: window at 78h, overlap area shared with file
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < nrf_pkg::RF_DEPTH; i++) begin
                data_mem[i] <= nrf_pkg::NIB_RESET; // [RQ5]
            end
        end else if (i_ce) begin
            if (is_rd) begin
                data_mem[nrf_pkg::WINDOW_ADDR] <= next_window; // [RQ11] [RQ21]
            end else if (is_wr && !c_acc) begin
                // same cells as memory, so no second copy exists
                data_mem[i_req.addr] <= data_mem[nrf_pkg::WINDOW_ADDR]; // [RQ8] [RQ14]
            end else if (is_alu) begin
                data_mem[gr_addr] <= alu_res; // [RQ4]
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_window    <= nrf_pkg::NIB_RESET;
            o_rdata     <= nrf_pkg::NIB_RESET;
            o_ptr       <= nrf_pkg::ROW_RESET;
            o_hole_warn <= 1'b0;
        end else if (i_ce) begin
            o_window    <= is_rd ? next_window : data_mem[nrf_pkg::WINDOW_ADDR];
            o_rdata     <= mem_val;
            o_ptr       <= operand_row_pointer;
            // flag a general row placed on uninstalled memory
            o_hole_warn <= gr_addr >= nrf_pkg::HOLE_LO && gr_addr <= nrf_pkg::HOLE_HI; // [RQ3]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    file_read_op_window_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ9]
        i_ce && is_rd |=> data_mem[nrf_pkg::WINDOW_ADDR] == $past(next_window))
        else $error("file read did not load window");
    file_write_op_ovl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ10]
        i_ce && is_wr && !c_acc && i_req.addr != nrf_pkg::WINDOW_ADDR
        |=> data_mem[$past(i_req.addr)] == $past(data_mem[nrf_pkg::WINDOW_ADDR]))
        else $error("overlap write lost");
    restart_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ17]
        ctrl_mem[nrf_pkg::TIMER_CTRL][nrf_pkg::TIMER_RESTART_BIT] == 1'b0)
        else $error("restart flag stored");
    ro_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ20]
        i_ce && is_wr && c_acc && RO_MASK[cidx]
        |=> ctrl_mem[$past(cidx)] == $past(ctrl_mem[cidx]))
        else $error("read-only control changed");
    unused_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ19]
        i_ce && is_wr && c_acc && !USED_MASK[cidx]
        |=> ctrl_mem[$past(cidx)] == $past(ctrl_mem[cidx]))
        else $error("unused control changed");
    ptr_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ2]
        i_ce && i_ptr_we |=> ##1 o_ptr == $past(i_ptr, 2))
        else $error("row pointer not loaded");
    ctrl_isolate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ14]
        i_ce && is_wr && c_acc
        |=> data_mem[$past(i_req.addr)] == $past(data_mem[i_req.addr])
            || $past(i_req.addr) == nrf_pkg::WINDOW_ADDR)
        else $error("control write hit memory");
    alu_op_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ4]
        i_ce && is_alu && i_req.alu == nrf_pkg::NRF_ALU_OR
        |=> data_mem[$past(gr_addr)] == ($past(gr_val) | $past(mem_val)))
        else $error("general row operation wrong");

    // ------------------------------------------------------------
    // checks: transfers through the window
    // ------------------------------------------------------------
    // a read-only nibble returns the live status input, never a stored copy
    ro_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ16]
        i_ce && is_rd && c_acc && USED_MASK[cidx] && RO_MASK[cidx]
        |=> data_mem[nrf_pkg::WINDOW_ADDR] == ($past(i_ro_data) & ~ZERO_BITS))
        else $error("read-only control read wrong");
    // an unused nibble reads the fixed filler value
    unused_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ19]
        i_ce && is_rd && c_acc && !USED_MASK[cidx]
        |=> data_mem[nrf_pkg::WINDOW_ADDR] == nrf_pkg::UNUSED_READ)
        else $error("unused control read wrong");
    // overlap reads come from the shared memory cell
    ovl_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ13]
        i_ce && is_rd && !c_acc
        |=> data_mem[nrf_pkg::WINDOW_ADDR] == $past(mem_val))
        else $error("overlap read wrong");
    // a writable control nibble is read back from its stored value
    ctrl_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ9]
        i_ce && is_rd && c_acc && USED_MASK[cidx] && !RO_MASK[cidx]
        |=> data_mem[nrf_pkg::WINDOW_ADDR] == $past(ctrl_mem[cidx]))
        else $error("control read wrong");
    // with no instruction the window keeps its value
    win_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ21]
        i_ce && i_req.op == nrf_pkg::NRF_OP_NONE
        |=> $stable(data_mem[nrf_pkg::WINDOW_ADDR]))
        else $error("window changed while idle");
    // the output follows the window cell one edge behind
    win_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ11]
        i_ce && i_req.op == nrf_pkg::NRF_OP_NONE
        |=> o_window == $past(data_mem[nrf_pkg::WINDOW_ADDR]))
        else $error("window output stale");
    // a low enable must freeze the window cell, the row pointer and the window output
    freeze_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ21]
        !i_ce |=> $stable(data_mem[nrf_pkg::WINDOW_ADDR])
            && $stable(operand_row_pointer) && $stable(o_window))
        else $error("state moved while frozen");

    // ------------------------------------------------------------
    // checks: control area
    // ------------------------------------------------------------
    // an accepted write stores the window with fixed bits cleared
    ctrl_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ10]
        i_ce && ctrl_wen && cidx != nrf_pkg::TIMER_CTRL
        |=> ctrl_mem[$past(cidx)] == ($past(data_mem[nrf_pkg::WINDOW_ADDR]) & ~ZERO_BITS))
        else $error("control write lost");
    // fixed-zero bits never pick up a one
    zero_bits_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ18]
        i_ce && ctrl_wen |=> (ctrl_mem[$past(cidx)] & ZERO_BITS) == 4'h0)
        else $error("fixed-zero bit set");
    // a one written to the restart flag gives a pulse
    restart_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ17]
        i_ce && ctrl_wen && cidx == nrf_pkg::TIMER_CTRL
            && data_mem[nrf_pkg::WINDOW_ADDR][nrf_pkg::TIMER_RESTART_BIT]
        |=> o_timer_restart)
        else $error("restart pulse missing");
    // no accepted control write, no pulse
    restart_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ17]
        i_ce && !ctrl_wen |=> !o_timer_restart)
        else $error("spurious restart pulse");
    // only the file write instruction may change a control nibble
    file_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ12]
        i_ce && !ctrl_wen |=> ctrl_mem[$past(cidx)] == $past(ctrl_mem[cidx]))
        else $error("control changed without write");

    // ------------------------------------------------------------
    // checks: general row
    // ------------------------------------------------------------
    // addition wraps at sixteen, no carry kept
    alu_add_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ4]
        i_ce && is_alu && i_req.alu == nrf_pkg::NRF_ALU_ADD
        |=> data_mem[$past(gr_addr)] == 4'($past(gr_val) + $past(mem_val)))
        else $error("general row add wrong");
    alu_and_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ4]
        i_ce && is_alu && i_req.alu == nrf_pkg::NRF_ALU_AND
        |=> data_mem[$past(gr_addr)] == ($past(gr_val) & $past(mem_val)))
        else $error("general row and wrong");
    alu_mov_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ4]
        i_ce && is_alu && i_req.alu == nrf_pkg::NRF_ALU_MOV
        |=> data_mem[$past(gr_addr)] == $past(mem_val))
        else $error("general row move wrong");
    // the pointer output trails the pointer by one edge
    ptr_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ2]
        i_ce |=> o_ptr == $past(operand_row_pointer))
        else $error("pointer output stale");
    // the warning tracks the general row address of the last request
    hole_warn_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ3]
        i_ce |=> o_hole_warn == ($past(gr_addr) >= nrf_pkg::HOLE_LO
            && $past(gr_addr) <= nrf_pkg::HOLE_HI))
        else $error("hole warning wrong");
endmodule : nrf_core

// ### verif/nrf_cpu_model.sv
// core stand-in: issues one transfer instruction at a time
// assumes the datapath samples requests on the rising edge of i_clk
`timescale 1ns/1ns
module nrf_cpu_model (
    input  wire logic         i_clk,
    output logic              o_ce,
    output nrf_pkg::nrf_req_t o_req,
    output logic              o_ptr_we,
    output logic [2:0]        o_ptr,
    output logic [3:0]        o_ro_data
);
    // quiet bus from time zero
    initial begin
        o_ce      = 1'b1;
        o_req     = '0;
        o_ptr_we  = 1'b0;
        o_ptr     = 3'h0;
        o_ro_data = 4'h0;
    end
    // drive after a falling edge; held until idle so back-to-back works
    task automatic issue(input nrf_pkg::nrf_op_t op, input nrf_pkg::nrf_alu_t alu,
                         input logic [6:0] addr, input logic [3:0] ro, input logic ce);
        @(negedge i_clk);
        o_req     = '{op, alu, 4'h8, addr}; // column 8 of row 7 is the window
        o_ro_data = ro;
        o_ce      = ce;
    endtask : issue
    task automatic idle();
        o_req.op = nrf_pkg::NRF_OP_NONE;
        o_ce     = 1'b1;
    endtask : idle
    // only fitted rows are named, never the gap at 40h-6eh
    task automatic set_row(input logic [2:0] row);
        @(negedge i_clk);
        o_ptr    = row;
        o_ptr_we = 1'b1;
        @(negedge i_clk);
        o_ptr_we = 1'b0;
        o_ptr    = ~row; // a stale value would hide a late load
    endtask : set_row
endmodule : nrf_cpu_model

// ### verif/testbench.sv
// self-checking bench for the register file datapath
// assumes the general row sits on row 7 so column 8 is the window
`timescale 1ns/1ns
module testbench;
    typedef struct {
        nrf_pkg::nrf_op_t  op;
        nrf_pkg::nrf_alu_t alu;
        logic [6:0]        addr;
        logic [3:0]        ro;
        logic [3:0]        win;
        logic              pulse;
    } nrf_row_t;
    localparam nrf_pkg::nrf_op_t  rd = nrf_pkg::NRF_OP_READ;
    localparam nrf_pkg::nrf_op_t  wr = nrf_pkg::NRF_OP_WRITE;
    localparam nrf_pkg::nrf_op_t  al = nrf_pkg::NRF_OP_ALU;
    localparam nrf_pkg::nrf_alu_t mv = nrf_pkg::NRF_ALU_MOV;
    localparam nrf_pkg::nrf_alu_t ad = nrf_pkg::NRF_ALU_ADD;
    localparam nrf_pkg::nrf_alu_t an = nrf_pkg::NRF_ALU_AND;
    localparam nrf_pkg::nrf_alu_t oo = nrf_pkg::NRF_ALU_OR;
    // op, alu, address, status nibble, window after, restart pulse
    nrf_row_t rows [17] = '{
        '{rd, mv, 7'h13, 4'ha, 4'ha, 1'b0},
        '{wr, mv, 7'h50, 4'ha, 4'ha, 1'b0},
        '{rd, mv, 7'h13, 4'h5, 4'h5, 1'b0},
        '{wr, mv, 7'h00, 4'h5, 4'h5, 1'b0},
        '{rd, mv, 7'h50, 4'h5, 4'ha, 1'b0},
        '{rd, mv, 7'h00, 4'h5, 4'h5, 1'b0},
        '{al, ad, 7'h50, 4'h5, 4'hf, 1'b0},
        '{al, ad, 7'h50, 4'h5, 4'h9, 1'b0}, // sum wraps at 16
        '{wr, mv, 7'h3f, 4'h5, 4'h9, 1'b0},
        '{rd, mv, 7'h3f, 4'h5, nrf_pkg::UNUSED_READ, 1'b0},
        '{al, oo, 7'h50, 4'h5, 4'ha, 1'b0},
        '{al, oo, 7'h00, 4'h5, 4'ha, 1'b0}, // memory 00h, not control 00h
        '{rd, mv, 7'h13, 4'hf, 4'hf, 1'b0},
        '{wr, mv, 7'h11, 4'hf, 4'hf, 1'b1},
        '{rd, mv, 7'h11, 4'hf, 4'hb, 1'b0},
        '{al, an, 7'h50, 4'hf, 4'ha, 1'b0},
        '{al, mv, 7'h00, 4'hf, 4'h0, 1'b0}
    };
    logic              i_clk = 1'b0;
    logic              i_rst_n = 1'b0;
    logic              ce;
    nrf_pkg::nrf_req_t req;
    logic              ptr_we;
    logic [2:0]        ptr;
    logic [3:0]        ro_data;
    logic [3:0]        o_window;
    logic [2:0]        o_ptr;
    logic              o_timer_restart;
    logic              o_hole_warn;
    int                errors = 0;
    int                comparisons = 0;
    // 100 ns period
    always #50 i_clk = ~i_clk;
    nrf_cpu_model i_nrf_cpu_model (.i_clk(i_clk), .o_ce(ce), .o_req(req),
        .o_ptr_we(ptr_we), .o_ptr(ptr), .o_ro_data(ro_data));
    nrf_core i_nrf_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_req(req),
        .i_ptr_we(ptr_we), .i_ptr(ptr), .i_ro_data(ro_data), .o_window(o_window),
        .o_rdata(), .o_ptr(o_ptr), .o_timer_restart(o_timer_restart),
        .o_hole_warn(o_hole_warn));
    task automatic check_nib(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_nib
    task automatic check_bit(input logic got, input logic exp);
        check_nib({3'h0, got}, {3'h0, exp});
    endtask : check_bit
    // pulse is seen one edge after the take, the window one edge later
    task automatic settle(input logic pulse, input logic [3:0] win);
        @(negedge i_clk);
        i_nrf_cpu_model.idle();
        check_bit(o_timer_restart, pulse);
        @(negedge i_clk);
        check_nib(o_window, win);
        check_bit(o_hole_warn, 1'b0);
    endtask : settle
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    // tests need about 80 cycles; a hang is cut at 2000
    initial begin
        #200_000;
        errors++;
        finish_test();
    end
    initial begin
        repeat (12) @(negedge i_clk);
        check_nib(o_window, nrf_pkg::NIB_RESET);
        i_rst_n = 1'b1;
        $display("test reset done");
        i_nrf_cpu_model.set_row(3'h7);
        @(negedge i_clk);
        check_nib({1'b0, o_ptr}, 4'h7);
        foreach (rows[k]) begin
            i_nrf_cpu_model.issue(rows[k].op, rows[k].alu, rows[k].addr, rows[k].ro, 1'b1);
            settle(rows[k].pulse, rows[k].win);
        end
        $display("test table done");
        // four transfers in consecutive cycles through a shared cell
        i_nrf_cpu_model.issue(rd, mv, 7'h13, 4'h6, 1'b1);
        i_nrf_cpu_model.issue(wr, mv, 7'h60, 4'h6, 1'b1);
        i_nrf_cpu_model.issue(rd, mv, 7'h13, 4'h1, 1'b1);
        i_nrf_cpu_model.issue(rd, mv, 7'h60, 4'h1, 1'b1);
        settle(1'b0, 4'h6);
        // a frozen clock enable leaves the window alone
        i_nrf_cpu_model.issue(rd, mv, 7'h13, 4'h3, 1'b0);
        settle(1'b0, 4'h6);
        i_rst_n = 1'b0;
        @(negedge i_clk);
        check_nib(o_window, nrf_pkg::NIB_RESET);
        $display("test awkward done");
        finish_test();
    end
endmodule : testbench
